// ===== logic/ardc_pkg.sv
// shared constants and types for the converter reference and decimation control
`default_nettype none
package ardc_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
  localparam logic [7:0] ADDR_AUX_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_CURRENT = 8'h10;
  localparam logic [7:0] ADDR_DECIM = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PRIM_OFFSET = 8'h1c;
  localparam logic [7:0] ADDR_PRIM_GAIN = 8'h20;
  localparam logic [7:0] ADDR_AUX_OFFSET = 8'h24;
  localparam logic [7:0] ADDR_AUX_GAIN = 8'h28;
  localparam logic [7:0] ADDR_PRIM_RESULT = 8'h2c;
  localparam logic [7:0] ADDR_AUX_RESULT = 8'h30;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int MODE_CHOP_OFF_BIT = 3;
  localparam int MODE_AUX_EN_BIT = 4;
  localparam int MODE_PRIM_EN_BIT = 5;
  localparam int MODE_NOTCH60_BIT = 6;
  localparam int ONE_BUF_LSB = 6;
  localparam int ONE_BUF_W = 2;
  localparam int ONE_DIFF_BIT = 5;
  localparam int TWO_CHAN_LSB = 0;
  localparam int TWO_CHAN_W = 4;
  localparam int TWO_REF_LSB = 6;
  localparam int TWO_REF_W = 2;
  localparam int AUX_REF_BIT = 6;
  localparam int BURNOUT_BIT = 6;
  localparam int ST_PRIM_RDY = 0;
  localparam int ST_AUX_RDY = 1;
  localparam int ST_NOREF = 2;
  localparam int ST_PRIM_ERR = 3;
  localparam int ST_AUX_ERR = 4;
  localparam int ST_CAL_BUSY = 5;
  localparam int ST_DECIM_LSB = 8;

  // ************************************************************
  // modes, channels, reference selections
  // ************************************************************
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_CONT = 3'h1;
  localparam logic [2:0] MODE_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_INT_FULL = 3'h5;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_SYS_FULL = 3'h7;
  localparam logic [3:0] CHAN_DIFF_PAIR_THREE = 4'h2;
  localparam logic [3:0] CHAN_DIFF_PAIR_FOUR = 4'h3;
  localparam logic [1:0] REF_MAIN_PAIR = 2'h0;
  localparam logic [1:0] REF_SECOND_PAIR = 2'h1;

  // ************************************************************
  // reset values and limits
  // ************************************************************
  localparam logic [7:0] DECIM_RESET = 8'h45;
  localparam logic [7:0] DECIM_MIN_NOCHOP = 8'h03;
  localparam logic [7:0] DECIM_MIN_CHOP = 8'h0d;
  localparam logic [23:0] CLAMP_CODE = 24'hffffff;
  localparam logic [15:0] BANDGAP_MV = 16'h04e2;
  localparam logic [15:0] EXT_REF_MV = 16'h09c4;
  localparam int REF_SCALE_NUM = 1024;
  localparam int REF_SCALE_DEN = 1000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int DECIM_STEP_NS = 244000;
  localparam int DECIM_STEP_CYCLES = DECIM_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    REFSRC_MAIN_PAIR,
    REFSRC_SECOND_PAIR,
    REFSRC_BANDGAP
  } ardc_ref_src_e;

  typedef struct packed {
    ardc_ref_src_e src;
    logic [15:0] fullscale_mv;
  } ardc_ref_ctl_s;

endpackage
`default_nettype wire

// ===== logic/ardc_conv_timer.sv
// conversion period timer: one period per decimation step count
`timescale 1ns/1ps
`default_nettype none
module ardc_conv_timer #(
  parameter int STEP_CYCLES = ardc_pkg::DECIM_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic restart_i,
  input wire logic run_i,
  input wire logic [7:0] decim_i,
  // event
  output logic done_o
);
  import ardc_pkg::*;

  logic [31:0] count;
  logic [31:0] period;
  logic [31:0] next_count;
  logic at_end;

  // conversion time grows by one step per decimation increment
  assign period = 32'(decim_i) * 32'(STEP_CYCLES);
  assign at_end = run_i && (count >= period - 32'h1);
  assign next_count = (restart_i || !run_i || at_end) ? 32'h0 : count + 32'h1;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count <= 32'h0;
      done_o <= 1'b0;
    end else begin
      count <= next_count;
      done_o <= at_end && !restart_i;
    end
  end

endmodule // ardc_conv_timer
`default_nettype wire

// ===== logic/ardc_ctl.sv
// reference selection, reference detect, calibration guard and decimation control
// What this block does
// - primary picks either external pair; auxiliary uses only the main pair
// - bandgap select bit makes that converter use internal reference, halving ranges
// - primary external full scale equals applied reference times 1.024
// - burnout control bit drives currents only on pairs three/four, differential
// - burnout currents act only with input buffering enabled
// - floating or low main reference sets the no-reference status flag
// - results of a converter on the main pair are clamped while no reference is present
// - no reference during calibration of a converter on the main pair blocks the coefficient write
// - a blocked calibration sets the affected converter's error bit
// - monitor watches only the main pair, never the second pair
// - decimation value sets sinc3 factor, 3 to 255 without chopping
// - with chopping, values below 13 act as 13, up to 255
// - update rate follows decimation across its chop-dependent range
// - mode bit 6 enables the extra 60 Hz notch
// - calibration uses the current software decimation value
// - decimation is an 8-bit field, bits 7 to 0
// - decimation resets to 0x45
// - each decimation step adds 0.244 ms of conversion time
// - writing 1 to mode bit 3 turns chopping off
`timescale 1ns/1ps
`default_nettype none
module ardc_ctl #(
  parameter int STEP_CYCLES = ardc_pkg::DECIM_STEP_CYCLES,
  parameter logic [23:0] OFFSET_RESET = 24'h800000,
  parameter logic [23:0] GAIN_RESET = 24'h555555
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // reference monitor, main pair only
  input wire logic main_ref_float_i,
  input wire logic main_ref_low_i,
  // filter outputs
  input wire logic [23:0] prim_filter_data_i,
  input wire logic prim_filter_valid_i,
  input wire logic [23:0] aux_filter_data_i,
  input wire logic aux_filter_valid_i,
  // analog and filter control
  output ardc_pkg::ardc_ref_ctl_s prim_ref_o,
  output ardc_pkg::ardc_ref_ctl_s aux_ref_o,
  output logic burnout_on_o,
  output logic [7:0] decim_factor_o,
  output logic chop_en_o,
  output logic notch60_en_o,
  output logic conv_tick_o
);
  import ardc_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [6:0] mode_reg;
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic aux_bandgap;
  logic burnout_req;
  logic [7:0] sinc_decimation_value;
  logic prim_rdy;
  logic aux_rdy;
  logic primary_error_flag;
  logic aux_error_flag;
  logic no_reference_flag;
  logic [23:0] prim_offset;
  logic [23:0] prim_gain;
  logic [23:0] aux_offset;
  logic [23:0] aux_gain;
  logic [23:0] prim_result;
  logic [23:0] aux_result;
  logic ack;

  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // ************************************************************
  // bus decode
  // ************************************************************
  wire req = avs_read | avs_write;
  wire wr_en = avs_write & ack;
  wire wr_mode = wr_en && (avs_address == ADDR_MODE);
  wire wr_one = wr_en && (avs_address == ADDR_CTRL_ONE);
  wire wr_two = wr_en && (avs_address == ADDR_CTRL_TWO);
  wire wr_aux = wr_en && (avs_address == ADDR_AUX_CTRL);
  wire wr_cur = wr_en && (avs_address == ADDR_CURRENT);
  wire wr_decim = wr_en && (avs_address == ADDR_DECIM);
  wire wr_status = wr_en && (avs_address == ADDR_STATUS);
  wire wr_poff = wr_en && (avs_address == ADDR_PRIM_OFFSET);
  wire wr_pgain = wr_en && (avs_address == ADDR_PRIM_GAIN);
  wire wr_aoff = wr_en && (avs_address == ADDR_AUX_OFFSET);
  wire wr_again = wr_en && (avs_address == ADDR_AUX_GAIN);

  // one wait cycle per access keeps read data registered
  assign avs_waitrequest = req & ~ack;

  // ************************************************************
  // reference selection
  // ************************************************************
  wire [1:0] prim_ref_code = ctrl_two[TWO_REF_LSB +: TWO_REF_W];
  wire prim_on_main = (prim_ref_code == REF_MAIN_PAIR);
  wire aux_on_main = ~aux_bandgap;
  wire [15:0] ext_scaled_mv = 16'((32'(EXT_REF_MV) * REF_SCALE_NUM) / REF_SCALE_DEN);

  ardc_ref_ctl_s next_prim_ref;
  ardc_ref_ctl_s next_aux_ref;
  always_comb begin
    if (prim_on_main) begin
      next_prim_ref.src = REFSRC_MAIN_PAIR;
      next_prim_ref.fullscale_mv = ext_scaled_mv;
    end else if (prim_ref_code == REF_SECOND_PAIR) begin
      next_prim_ref.src = REFSRC_SECOND_PAIR;
      next_prim_ref.fullscale_mv = ext_scaled_mv;
    end else begin
      next_prim_ref.src = REFSRC_BANDGAP;
      next_prim_ref.fullscale_mv = BANDGAP_MV;
    end
    if (aux_on_main) begin
      next_aux_ref.src = REFSRC_MAIN_PAIR;
      next_aux_ref.fullscale_mv = EXT_REF_MV;
    end else begin
      next_aux_ref.src = REFSRC_BANDGAP;
      next_aux_ref.fullscale_mv = BANDGAP_MV;
    end
  end

  // ************************************************************
  // burnout current gate
  // ************************************************************
  wire [3:0] chan = ctrl_two[TWO_CHAN_LSB +: TWO_CHAN_W];
  wire chan_ok = (chan == CHAN_DIFF_PAIR_THREE) || (chan == CHAN_DIFF_PAIR_FOUR);
  wire buffered = |ctrl_one[ONE_BUF_LSB +: ONE_BUF_W];
  wire next_burnout = burnout_req & chan_ok & ctrl_one[ONE_DIFF_BIT]
                      & buffered;

  // ************************************************************
  // decimation and filter options
  // ************************************************************
  wire chop_off = mode_reg[MODE_CHOP_OFF_BIT];
  wire [7:0] decim_min = chop_off ? DECIM_MIN_NOCHOP : DECIM_MIN_CHOP;
  // calibration and conversion both use the live software value
  wire [7:0] next_decim = (sinc_decimation_value < decim_min) ? decim_min
                          : sinc_decimation_value;

  // ************************************************************
  // reference monitor and calibration
  // ************************************************************
  // second pair has no monitor input at all
  wire next_noref = main_ref_float_i | main_ref_low_i;
  wire [2:0] mode = mode_reg[MODE_LSB +: MODE_W];
  wire cal_active = (mode == MODE_INT_ZERO) || (mode == MODE_INT_FULL)
                    || (mode == MODE_SYS_ZERO) || (mode == MODE_SYS_FULL);
  wire cal_gain = mode[0];
  wire prim_sel = mode_reg[MODE_PRIM_EN_BIT];
  wire aux_sel = mode_reg[MODE_AUX_EN_BIT];
  wire prim_bad = no_reference_flag & prim_on_main;
  wire aux_bad = no_reference_flag & aux_on_main;
  // a lost reference halts the calibration at once
  wire cal_halt = cal_active & ((prim_sel & prim_bad) | (aux_sel & aux_bad));
  wire run = (mode != MODE_IDLE) & (prim_sel | aux_sel);
  wire conv_done;
  wire cal_done = cal_active & conv_done & ~cal_halt;
  wire ld_poff = cal_done & prim_sel & ~cal_gain;
  wire ld_pgain = cal_done & prim_sel & cal_gain;
  wire ld_aoff = cal_done & aux_sel & ~cal_gain;
  wire ld_again = cal_done & aux_sel & cal_gain;
  wire set_perr = cal_halt & prim_sel & prim_bad;
  wire set_aerr = cal_halt & aux_sel & aux_bad;

  ardc_conv_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .restart_i(wr_mode),
    .run_i(run),
    .decim_i(next_decim),
    .done_o(conv_done)
  );

  // ************************************************************
  // read mux
  // ************************************************************
  wire [31:0] status_word = {16'h0, next_decim, 2'h0, cal_active, aux_error_flag,
                             primary_error_flag, no_reference_flag, aux_rdy, prim_rdy};
  logic [31:0] next_rdata;
  always_comb begin
    case (avs_address)
      ADDR_MODE: next_rdata = {25'h0, mode_reg};
      ADDR_CTRL_ONE: next_rdata = {24'h0, ctrl_one};
      ADDR_CTRL_TWO: next_rdata = {24'h0, ctrl_two};
      ADDR_AUX_CTRL: next_rdata = {25'h0, aux_bandgap, 6'h0};
      ADDR_CURRENT: next_rdata = {25'h0, burnout_req, 6'h0};
      ADDR_DECIM: next_rdata = {24'h0, sinc_decimation_value};
      ADDR_STATUS: next_rdata = status_word;
      ADDR_PRIM_OFFSET: next_rdata = {8'h0, prim_offset};
      ADDR_PRIM_GAIN: next_rdata = {8'h0, prim_gain};
      ADDR_AUX_OFFSET: next_rdata = {8'h0, aux_offset};
      ADDR_AUX_GAIN: next_rdata = {8'h0, aux_gain};
      ADDR_PRIM_RESULT: next_rdata = {8'h0, prim_result};
      ADDR_AUX_RESULT: next_rdata = {8'h0, aux_result};
      default: next_rdata = 32'h0;
    endcase
  end

  // ************************************************************
  // bus and control registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
      mode_reg <= 7'h0;
      ctrl_one <= 8'h0;
      ctrl_two <= 8'h0;
      aux_bandgap <= 1'b0;
      burnout_req <= 1'b0;
      sinc_decimation_value <= DECIM_RESET;
    end else begin
      ack <= req & ~ack;
      if (avs_read & ~ack) avs_readdata <= next_rdata;
      if (wr_mode) mode_reg <= avs_writedata[6:0];
      else if (cal_halt || cal_done) mode_reg[MODE_LSB +: MODE_W] <= MODE_IDLE;
      if (wr_one) ctrl_one <= avs_writedata[7:0];
      if (wr_two) ctrl_two <= avs_writedata[7:0];
      if (wr_aux) aux_bandgap <= avs_writedata[AUX_REF_BIT];
      if (wr_cur) burnout_req <= avs_writedata[BURNOUT_BIT];
      if (wr_decim) sinc_decimation_value <= avs_writedata[7:0];
    end
  end

  // ************************************************************
  // status, coefficients and results
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      no_reference_flag <= 1'b0;
      prim_rdy <= 1'b0;
      aux_rdy <= 1'b0;
      primary_error_flag <= 1'b0;
      aux_error_flag <= 1'b0;
      prim_offset <= OFFSET_RESET;
      prim_gain <= GAIN_RESET;
      aux_offset <= OFFSET_RESET;
      aux_gain <= GAIN_RESET;
      prim_result <= 24'h0;
      aux_result <= 24'h0;
    end else begin
      no_reference_flag <= next_noref;
      // hardware set wins over a software clear in the same cycle
      prim_rdy <= sticky(prim_rdy, prim_filter_valid_i | ld_poff | ld_pgain,
                         wr_status & avs_writedata[ST_PRIM_RDY]);
      aux_rdy <= sticky(aux_rdy, aux_filter_valid_i | ld_aoff | ld_again,
                        wr_status & avs_writedata[ST_AUX_RDY]);
      primary_error_flag <= sticky(primary_error_flag, set_perr,
                                   wr_status & avs_writedata[ST_PRIM_ERR]);
      aux_error_flag <= sticky(aux_error_flag, set_aerr,
                               wr_status & avs_writedata[ST_AUX_ERR]);
      if (ld_poff) prim_offset <= prim_filter_data_i;
      else if (wr_poff) prim_offset <= avs_writedata[23:0];
      if (ld_pgain) prim_gain <= prim_filter_data_i;
      else if (wr_pgain) prim_gain <= avs_writedata[23:0];
      if (ld_aoff) aux_offset <= aux_filter_data_i;
      else if (wr_aoff) aux_offset <= avs_writedata[23:0];
      if (ld_again) aux_gain <= aux_filter_data_i;
      else if (wr_again) aux_gain <= avs_writedata[23:0];
      if (prim_filter_valid_i)
        prim_result <= prim_bad ? CLAMP_CODE : prim_filter_data_i;
      if (aux_filter_valid_i)
        aux_result <= aux_bad ? CLAMP_CODE : aux_filter_data_i;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prim_ref_o <= '{src: REFSRC_MAIN_PAIR, fullscale_mv: 16'h0};
      aux_ref_o <= '{src: REFSRC_MAIN_PAIR, fullscale_mv: 16'h0};
      burnout_on_o <= 1'b0;
      decim_factor_o <= DECIM_RESET;
      chop_en_o <= 1'b1;
      notch60_en_o <= 1'b0;
      conv_tick_o <= 1'b0;
    end else begin
      prim_ref_o <= next_prim_ref;
      aux_ref_o <= next_aux_ref;
      burnout_on_o <= next_burnout;
      decim_factor_o <= next_decim;
      chop_en_o <= ~chop_off;
      notch60_en_o <= mode_reg[MODE_NOTCH60_BIT];
      conv_tick_o <= conv_done;
    end
  end

endmodule // ardc_ctl
`default_nettype wire

// ===== tb/ardc_ref_model.sv
// model of the external reference pins and the bridge filter words
`timescale 1ns/1ps
`default_nettype none
module ardc_ref_model (
  // clock and fault control
  input wire logic clk_i,
  input wire logic flt_i,
  input wire logic low_i,
  input wire logic [23:0] word_i,
  // toward the block
  output logic float_o,
  output logic low_o,
  output logic [23:0] data_o,
  output logic valid_o
);
  logic [2:0] cnt = 3'h0;
  // only the main pair has a detector behind it
  assign float_o = flt_i;
  assign low_o = low_i;
  always_ff @(posedge clk_i) begin
    cnt <= cnt + 3'h1;
    valid_o <= (cnt == 3'h7);
    data_o <= word_i;
  end
endmodule // ardc_ref_model
`default_nettype wire

// ===== tb/ardc_ctl_assertions.sv
// concurrent checks on the control block's ports
`timescale 1ns/1ps
`default_nettype none
module ardc_ctl_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // bus
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // control outputs
  input wire ardc_pkg::ardc_ref_ctl_s prim_ref_o,
  input wire ardc_pkg::ardc_ref_ctl_s aux_ref_o,
  input wire logic [7:0] decim_factor_o,
  input wire logic chop_en_o,
  input wire logic notch60_en_o
);
  import ardc_pkg::*;
  logic mode_wr;
  assign mode_wr = avs_write && !avs_waitrequest && (avs_address == ADDR_MODE);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ************************************************************
  // properties
  // ************************************************************
  // two cycles covers either output latency
  property p_chop_bit;
    mode_wr |-> ##2 (chop_en_o == !$past(avs_writedata[MODE_CHOP_OFF_BIT], 2));
  endproperty
  a_chop_bit: assert property (p_chop_bit) else $error("chop enable wrong");
  property p_notch_bit;
    mode_wr |-> ##2 (notch60_en_o == $past(avs_writedata[MODE_NOTCH60_BIT], 2));
  endproperty
  a_notch_bit: assert property (p_notch_bit) else $error("notch enable wrong");
  property p_decim_min;
    decim_factor_o >= DECIM_MIN_NOCHOP;
  endproperty
  a_decim_min: assert property (p_decim_min) else $error("decimation below 3");
  property p_chop_min;
    chop_en_o && $past(chop_en_o) && $past(chop_en_o, 2) |-> decim_factor_o >= DECIM_MIN_CHOP;
  endproperty
  a_chop_min: assert property (p_chop_min) else $error("chopped decimation below 13");
  property p_decim_reset;
    $fell(reset_i) |-> decim_factor_o == DECIM_RESET;
  endproperty
  a_decim_reset: assert property (p_decim_reset) else $error("decimation reset wrong");
  property p_prim_bg;
    prim_ref_o.src == REFSRC_BANDGAP |-> prim_ref_o.fullscale_mv == BANDGAP_MV;
  endproperty
  a_prim_bg: assert property (p_prim_bg) else $error("bandgap full scale wrong");
  property p_prim_ext;
    !$past(reset_i) && !$past(reset_i, 2) && prim_ref_o.src != REFSRC_BANDGAP
      |-> prim_ref_o.fullscale_mv == 16'h0a00;
  endproperty
  a_prim_ext: assert property (p_prim_ext) else $error("external full scale wrong");
  property p_aux_pair;
    aux_ref_o.src != REFSRC_SECOND_PAIR;
  endproperty
  a_aux_pair: assert property (p_aux_pair) else $error("aux on second pair");
endmodule // ardc_ctl_assertions
bind ardc_ctl ardc_ctl_assertions ardc_ctl_assertions_i (.clk_i, .reset_i, .avs_address,
  .avs_write, .avs_writedata, .avs_waitrequest, .prim_ref_o, .aux_ref_o, .decim_factor_o,
  .chop_en_o, .notch60_en_o);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the reference and decimation control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ardc_pkg::*;
  localparam int STEP = 3;
  // buffer cfg value taken as buffering on
  localparam logic [1:0] BUF_ON = 2'h1;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, main_ref_float_i, main_ref_low_i, prim_filter_valid_i;
  logic flt = 1'b0;
  logic low = 1'b0;
  logic [23:0] word = 24'h123456;
  logic [23:0] prim_filter_data_i;
  ardc_ref_ctl_s prim_ref_o, aux_ref_o;
  logic burnout_on_o, chop_en_o, notch60_en_o, conv_tick_o;
  logic [7:0] decim_factor_o;
  logic [7:0] tbl [6] = '{8'h00, 8'h02, 8'h03, 8'h0c, 8'h0d, 8'hff};
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  ardc_ctl #(.STEP_CYCLES(STEP)) ardc_ctl_i (.clk_i, .reset_i, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .main_ref_float_i,
    .main_ref_low_i, .prim_filter_data_i, .prim_filter_valid_i,
    .aux_filter_data_i(prim_filter_data_i), .aux_filter_valid_i(prim_filter_valid_i),
    .prim_ref_o, .aux_ref_o, .burnout_on_o, .decim_factor_o, .chop_en_o, .notch60_en_o,
    .conv_tick_o);
  ardc_ref_model ardc_ref_model_i (.clk_i, .flt_i(flt), .low_i(low), .word_i(word),
    .float_o(main_ref_float_i), .low_o(main_ref_low_i), .data_o(prim_filter_data_i),
    .valid_o(prim_filter_valid_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic finish_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until the edge where waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // waitrequest and read data are both judged at the same rising edge
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    chk(decim_factor_o, DECIM_RESET);
    chk(chop_en_o, 1'b1);
    rdc(ADDR_DECIM, 32'hff, 32'h45);
    rdc(ADDR_STATUS, 32'hff00, 32'h4500);
    rdc(8'h3c, 32'hffffffff, 32'h0);
  endtask
  task automatic t_ref;
    logic [1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      wr(ADDR_CTRL_TWO, {24'h0, v, 6'h0});
      wr(ADDR_AUX_CTRL, {25'h0, v[0], 6'h0});
      cyc(2);
      chk(prim_ref_o.src, v[1] ? 2'(REFSRC_BANDGAP) : {1'b0, v[0]});
      chk(prim_ref_o.fullscale_mv, v[1] ? BANDGAP_MV : 16'h0a00);
      chk(aux_ref_o.src, v[0] ? 2'(REFSRC_BANDGAP) : 2'(REFSRC_MAIN_PAIR));
      chk(aux_ref_o.fullscale_mv, v[0] ? BANDGAP_MV : EXT_REF_MV);
    end
  endtask
  task automatic t_burn;
    logic [3:0] i;
    for (int k = 0; k < 17; k++) begin
      i = (k == 16) ? 4'h7 : k[3:0];
      wr(ADDR_CTRL_ONE, {24'h0, i[2] ? BUF_ON : 2'h0, i[1], 5'h0});
      wr(ADDR_CTRL_TWO, {28'h0, (k == 16) ? CHAN_DIFF_PAIR_FOUR
        : i[3] ? CHAN_DIFF_PAIR_THREE : 4'h0});
      wr(ADDR_CURRENT, {25'h0, i[0], 6'h0});
      cyc(2);
      chk(burnout_on_o, (k == 16) || (i == 4'hf));
    end
  endtask
  task automatic t_decim;
    logic [7:0] v, e;
    logic c, n;
    for (int k = 0; k < 12; k++) begin
      v = tbl[k / 2];
      c = k[0];
      n = (k >= 10);
      wr(ADDR_DECIM, {24'h0, v});
      // notch only with decimation 255, nominal modulator rate assumed
      wr(ADDR_MODE, {25'h0, n, 2'h0, c, 3'h0});
      rdc(ADDR_DECIM, 32'hff, {24'h0, v});
      cyc(2);
      e = c ? ((v < 8'h03) ? 8'h03 : v) : ((v < 8'h0d) ? 8'h0d : v);
      chk(decim_factor_o, e);
      chk(chop_en_o, !c);
      chk(notch60_en_o, n);
    end
  endtask
  task automatic t_noref;
    wr(ADDR_CTRL_TWO, 32'h0);
    wr(ADDR_MODE, 32'h21);
    flt <= 1'b1;
    cyc(12);
    rdc(ADDR_STATUS, 32'h4, 32'h4);
    rdc(ADDR_PRIM_RESULT, 32'hffffff, {8'h0, CLAMP_CODE});
    flt <= 1'b0;
    low <= 1'b1;
    cyc(2);
    rdc(ADDR_STATUS, 32'h4, 32'h4);
    low <= 1'b0;
    word <= 24'h5a0f3c;
    cyc(12);
    rdc(ADDR_STATUS, 32'h4, 32'h0);
    rdc(ADDR_PRIM_RESULT, 32'hffffff, 32'h5a0f3c);
    wr(ADDR_CTRL_TWO, {24'h0, REF_SECOND_PAIR, 6'h0});
    flt <= 1'b1;
    word <= 24'h00c3a5;
    cyc(12);
    rdc(ADDR_PRIM_RESULT, 32'hffffff, 32'h00c3a5);
    flt <= 1'b0;
    wr(ADDR_MODE, 32'h0);
  endtask
  task automatic t_cal;
    int n;
    wr(ADDR_CTRL_TWO, 32'h0);
    wr(ADDR_AUX_CTRL, 32'h0);
    wr(ADDR_DECIM, 32'h14);
    word <= 24'h2468ac;
    cyc(10);
    wr(ADDR_MODE, 32'h24);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (conv_tick_o !== 1'b1 && n < 200);
    // twenty steps of STEP cycles, edge slack either side
    chk(32'(n >= 59 && n <= 62), 32'h1);
    cyc(4);
    rdc(ADDR_PRIM_OFFSET, 32'hffffff, 32'h2468ac);
    rdc(ADDR_MODE, 32'h7, 32'h0);
    rdc(ADDR_STATUS, 32'h18, 32'h0);
    wr(ADDR_MODE, 32'h35);
    cyc(5);
    @(posedge clk_i);
    flt <= 1'b1;
    cyc(3);
    rdc(ADDR_MODE, 32'h7, 32'h0);
    rdc(ADDR_STATUS, 32'h18, 32'h18);
    rdc(ADDR_PRIM_GAIN, 32'hffffff, 32'h555555);
    rdc(ADDR_AUX_GAIN, 32'hffffff, 32'h555555);
    flt <= 1'b0;
    wr(ADDR_STATUS, 32'h18);
    rdc(ADDR_STATUS, 32'h18, 32'h0);
    // system full scale on primary, then system zero on auxiliary
    word <= 24'h13579b;
    wr(ADDR_MODE, 32'h27);
    cyc(70);
    wr(ADDR_MODE, 32'h16);
    cyc(70);
    rdc(ADDR_PRIM_GAIN, 32'hffffff, 32'h13579b);
    rdc(ADDR_AUX_OFFSET, 32'hffffff, 32'h13579b);
    rdc(ADDR_STATUS, 32'h18, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    t_reset();
    t_ref();
    t_burn();
    t_decim();
    t_noref();
    t_cal();
    finish_test();
  end
endmodule // tb
`default_nettype wire
